// [hdl/opmode_consts.vh]
/*
 * constants for the operating-mode block control: mode codes, register
 * offsets, mode field codes, reset values and transceiver state codes.
 * assumes inclusion by bare name from design and testbench files.
 */
`ifndef OPMODE_CONSTS_VH
`define OPMODE_CONSTS_VH

// operating modes
`define MODE_OFF 3'h0
`define MODE_FNORM 3'h1
`define MODE_STBY 3'h2
`define MODE_NORM 3'h3
`define MODE_SLEEP 3'h4
`define MODE_RESET 3'h5
`define MODE_OVLD 3'h6
`define MODE_FSP 3'h7

// register byte offsets
`define OFS_MODE 8'h00
`define OFS_REG_CTRL 8'h04
`define OFS_HV_CTRL 8'h08
`define OFS_CAN_CTRL 8'h0c
`define OFS_LIN_CTRL 8'h10
`define OFS_FS_CTRL 8'h14
`define OFS_WD_CTRL 8'h18
`define OFS_STATUS 8'h1c

// reset values
`define RST_MODE 3'h0
`define RST_AUX 2'h0
`define RST_BB 2'h0
`define RST_CAN 2'h0
`define RST_LIN 2'h0
`define RST_WD 3'h2
`define BB_DEFAULT 2'h0
`define WD_OFF 3'h0
// synchroniser idle: {uv, can sd, can wake, can rx, lin wake[1:0], lin rx[1:0]}
`define SYNC_RST 8'h13

// transceiver states
`define XCVR_OFF 2'h0
`define XCVR_ACTIVE 2'h1
`define XCVR_LISTEN 2'h2
`define XCVR_OFFLINE 2'h3
`define CAN_BIAS 3'h4

// mode field codes that put receive pins onto bus status
`define FLD_STBY_STATUS 2'h3
`define FLD_NORM_ACT 2'h1
`define FLD_NORM_LISTEN 2'h2

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [hdl/reg_word.v]
/*
 * one software register word with synchronous reset and a single write enable.
 * assumes a single clock aclk and active-low synchronous reset.
 */
`timescale 1ns/1ps
module reg_word #(
  parameter W = 8,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  input wire aclk,
  input wire aresetn,
  input wire we,
  input wire [W-1:0] wdata,
  output reg [W-1:0] q
);
  always @(posedge aclk) begin
    if (!aresetn) begin
      q <= RST;
    end else if (we) begin
      q <= wdata;
    end
  end
endmodule

// [hdl/opmode_ctrl.v]
/*
 * operating-mode block control: decodes the current operating mode and
 * software configuration into enables for regulators, converter, hv pins,
 * can/lin transceivers, aux output pin, limp output, reset out, receive
 * pins, serial port and watchdog. registers over axi4-lite.
 * assumes software sets mode through the axi mode register and the pins are synchronised
 * here; transceiver internals lie outside.
 */
// How it works
// - digital pins may go inactive on main regulator undervoltage; outputs gated then.
// - main regulator off in sleep, overload, off; on otherwise.
// - aux regulator follows field; forced on in forced normal, off in off/overload.
// - hv pins follow config, low-side off, in standby/sleep/reset/fsp; off/fail-safe elsewhere.
// - in normal hv pins follow config fully including low-side drivers.
// - only hv pins present in the variant are controlled.
// - converter follows config in standby/normal/sleep, default in fnorm, on in reset/fsp.
// - can state from field, limited per mode; off in off and overload.
// - each lin follows its field, limited per mode; off in off and overload.
// - second lin and its receive pin controlled only if variant provides it.
// - aux output pin per two fail-safe fields in listed modes, else off.
// - in sleep the aux output pin works open-drain only.
// - limp follows control bit; forced in overload/fsp; floats in off/fnorm.
// - watchdog follows field in standby, normal, sleep; off elsewhere.
`timescale 1ns/1ps
`include "opmode_consts.vh"
module opmode_ctrl #(
  parameter HV_PINS = 8,
  parameter [7:0] HV_PRESENT = 8'hff,
  parameter LIN2_PRESENT = 1
) (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire main_reg_uv,
  input wire can_shutdown,
  input wire can_wake,
  input wire can_bus_rx,
  input wire [1:0] lin_wake,
  input wire [1:0] lin_bus_rx,
  output reg main_regulator_en,
  output reg aux_regulator_en,
  output reg [HV_PINS-1:0] hv_pin_en,
  output reg [HV_PINS-1:0] hv_pin_ls_en,
  output reg [HV_PINS-1:0] hv_pin_failsafe,
  output reg buck_boost_en,
  output reg buck_boost_default,
  output reg [2:0] can_state,
  output reg [3:0] lin_state,
  output reg aux_pin_out,
  output reg aux_pin_oe,
  output reg aux_pin_open_drain,
  output reg limp_out,
  output reg limp_oe,
  output reg reset_out_low,
  output reg can_rx_out,
  output reg [1:0] lin_rx_out,
  output reg spi_active,
  output reg spi_limited,
  output reg watchdog_en,
  output reg [2:0] watchdog_mode
);
  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  // receive lines reset to their idle high level
  reg [7:0] sync1_q;
  reg [7:0] sync2_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= `SYNC_RST;
      sync2_q <= `SYNC_RST;
    end else begin
      sync1_q <= {main_reg_uv, can_shutdown, can_wake, can_bus_rx, lin_wake, lin_bus_rx};
      sync2_q <= sync1_q;
    end
  end
  wire uv = sync2_q[7];
  wire can_sd = sync2_q[6];
  wire can_wk = sync2_q[5];
  wire can_rx = sync2_q[4];
  wire [1:0] lin_wk = sync2_q[3:2];
  wire [1:0] lin_rx = sync2_q[1:0];

  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  reg aw_held_q;
  reg w_held_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire aw_ok = aw_held_q || (s_axi_awvalid && s_axi_awready);
  wire w_ok = w_held_q || (s_axi_wvalid && s_axi_wready);
  wire [7:0] wa = aw_held_q ? awaddr_q : s_axi_awaddr[7:0];
  wire [31:0] wd = w_held_q ? wdata_q : s_axi_wdata;
  wire [3:0] ws = w_held_q ? wstrb_q : s_axi_wstrb;
  wire do_wr = aw_ok && w_ok && !s_axi_bvalid;
  wire wr_hi_ok = (s_axi_awaddr[31:8] == 24'h000000) || aw_held_q;
  wire wr_map = (wa[1:0] == 2'h0) && (wa <= `OFS_STATUS) && wr_hi_ok;
  wire wen = do_wr && ws[0] && wr_map && (wa != `OFS_STATUS);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (do_wr) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_held_q <= 1'b1;
          awaddr_q <= (s_axi_awaddr[31:8] == 24'h000000) ? s_axi_awaddr[7:0] : 8'hff;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_held_q <= 1'b1;
          wdata_q <= s_axi_wdata;
          wstrb_q <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  wire [2:0] mode;
  wire [1:0] aux_reg_ctrl;
  wire [1:0] bb_ctrl;
  wire [2*HV_PINS-1:0] hv_ctrl;
  wire [1:0] can_mode_field;
  wire [3:0] lin_mode_field;
  wire [2:0] fs_ctrl;
  wire [2:0] watchdog_mode_field;
  wire limp_home_ctrl = fs_ctrl[2];
  wire pin_drive_ctrl = fs_ctrl[1];
  wire diag_drive_ctrl = fs_ctrl[0];

  reg_word #(.W(3), .RST(`RST_MODE)) u_mode (
    .aclk(aclk), .aresetn(aresetn), .we(wen && wa == `OFS_MODE),
    .wdata(wd[2:0]), .q(mode));
  reg_word #(.W(4), .RST({`RST_BB, `RST_AUX})) u_regc (
    .aclk(aclk), .aresetn(aresetn), .we(wen && wa == `OFS_REG_CTRL),
    .wdata(wd[3:0]), .q({bb_ctrl, aux_reg_ctrl}));
  reg_word #(.W(2*HV_PINS)) u_hv (
    .aclk(aclk), .aresetn(aresetn), .we(wen && wa == `OFS_HV_CTRL && ws[1]),
    .wdata(wd[2*HV_PINS-1:0]), .q(hv_ctrl));
  reg_word #(.W(2), .RST(`RST_CAN)) u_can (
    .aclk(aclk), .aresetn(aresetn), .we(wen && wa == `OFS_CAN_CTRL),
    .wdata(wd[1:0]), .q(can_mode_field));
  reg_word #(.W(4), .RST({`RST_LIN, `RST_LIN})) u_lin (
    .aclk(aclk), .aresetn(aresetn), .we(wen && wa == `OFS_LIN_CTRL),
    .wdata(wd[3:0]), .q(lin_mode_field));
  reg_word #(.W(3)) u_fs (
    .aclk(aclk), .aresetn(aresetn), .we(wen && wa == `OFS_FS_CTRL),
    .wdata(wd[2:0]), .q(fs_ctrl));
  reg_word #(.W(3), .RST(`RST_WD)) u_wd (
    .aclk(aclk), .aresetn(aresetn), .we(wen && wa == `OFS_WD_CTRL),
    .wdata(wd[2:0]), .q(watchdog_mode_field));

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  reg [31:0] rd_d;
  reg rd_err;
  always @* begin
    rd_d = 32'h00000000;
    rd_err = 1'b0;
    if (s_axi_araddr[31:8] != 24'h000000 || s_axi_araddr[1:0] != 2'h0) begin
      rd_err = 1'b1;
    end else begin
      case (s_axi_araddr[7:0])
        `OFS_MODE: rd_d[2:0] = mode;
        `OFS_REG_CTRL: rd_d[3:0] = {bb_ctrl, aux_reg_ctrl};
        `OFS_HV_CTRL: rd_d[2*HV_PINS-1:0] = hv_ctrl;
        `OFS_CAN_CTRL: rd_d[1:0] = can_mode_field;
        `OFS_LIN_CTRL: rd_d[3:0] = lin_mode_field;
        `OFS_FS_CTRL: rd_d[2:0] = fs_ctrl;
        `OFS_WD_CTRL: rd_d[2:0] = watchdog_mode_field;
        `OFS_STATUS: rd_d[12:0] = {uv, can_state, lin_state, main_regulator_en,
                                   aux_regulator_en, buck_boost_en, watchdog_en, reset_out_low};
        default: rd_err = 1'b1;
      endcase
    end
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_d;
      s_axi_rresp <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  wire m_off = (mode == `MODE_OFF);
  wire m_fn = (mode == `MODE_FNORM);
  wire m_sb = (mode == `MODE_STBY);
  wire m_nm = (mode == `MODE_NORM);
  wire m_sl = (mode == `MODE_SLEEP);
  wire m_rs = (mode == `MODE_RESET);
  wire m_ov = (mode == `MODE_OVLD);
  wire m_fsp = (mode == `MODE_FSP);
  wire m_cfg = m_sb || m_nm || m_sl || m_rs || m_fsp;

  function [1:0] lin_sel;
    input [1:0] fld;
    input [2:0] md;
    begin
      case (md)
        `MODE_FNORM: lin_sel = `XCVR_ACTIVE;
        `MODE_STBY: lin_sel = (fld == `XCVR_LISTEN) ? `XCVR_LISTEN : `XCVR_OFFLINE;
        `MODE_NORM: lin_sel = (fld == `XCVR_OFF) ? `XCVR_OFFLINE : fld;
        `MODE_SLEEP, `MODE_RESET, `MODE_FSP: lin_sel = `XCVR_OFFLINE;
        default: lin_sel = `XCVR_OFF;
      endcase
    end
  endfunction

  function rx_sel;
    input [1:0] fld;
    input [2:0] md;
    input wk;
    input bus;
    begin
      case (md)
        `MODE_FNORM: rx_sel = bus;
        `MODE_STBY: rx_sel = (fld == `FLD_STBY_STATUS) ? bus : !wk;
        `MODE_NORM: rx_sel = (fld == `FLD_NORM_ACT || fld == `FLD_NORM_LISTEN) ? bus : !wk;
        `MODE_RESET: rx_sel = !wk;
        default: rx_sel = 1'b1;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // output registers
  // ---------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      main_regulator_en <= 1'b0;
      aux_regulator_en <= 1'b0;
      buck_boost_en <= 1'b0;
      buck_boost_default <= 1'b0;
      can_state <= {1'b0, `XCVR_OFF};
      aux_pin_out <= 1'b0;
      aux_pin_oe <= 1'b0;
      aux_pin_open_drain <= 1'b0;
      limp_out <= 1'b0;
      limp_oe <= 1'b0;
      reset_out_low <= 1'b1;
      can_rx_out <= 1'b1;
      spi_active <= 1'b0;
      spi_limited <= 1'b0;
      watchdog_en <= 1'b0;
      watchdog_mode <= `RST_WD;
    end else begin
      main_regulator_en <= !(m_sl || m_ov || m_off);
      aux_regulator_en <= m_fn || (m_cfg && aux_reg_ctrl != `RST_AUX);
      buck_boost_en <= !(m_off || m_ov);
      buck_boost_default <= m_fn || ((m_sb || m_nm || m_sl) && bb_ctrl == `BB_DEFAULT);
      if (m_off || m_ov) begin
        can_state <= {1'b0, `XCVR_OFF};
      end else if (m_fn) begin
        can_state <= {1'b0, (can_mode_field == `XCVR_LISTEN) ? `XCVR_LISTEN : `XCVR_ACTIVE};
      end else if (m_nm && can_sd) begin
        can_state <= {1'b0, `XCVR_OFF};
      end else if (m_nm && can_mode_field != `XCVR_OFF) begin
        can_state <= {1'b0, can_mode_field};
      end else if (m_sb && can_mode_field == `XCVR_LISTEN) begin
        can_state <= {1'b0, `XCVR_LISTEN};
      end else begin
        can_state <= (can_mode_field == `XCVR_OFFLINE) ? {1'b0, `XCVR_OFFLINE} : `CAN_BIAS;
      end
      aux_pin_out <= m_cfg && pin_drive_ctrl && !(m_sl && diag_drive_ctrl);
      aux_pin_oe <= m_cfg && (m_sl ? !pin_drive_ctrl : 1'b1);
      aux_pin_open_drain <= m_sl;
      limp_oe <= (m_ov || m_fsp) || (!(m_off || m_fn) && limp_home_ctrl);
      limp_out <= 1'b0;
      reset_out_low <= !(m_fn || m_sb || m_nm);
      can_rx_out <= uv ? 1'b1 : rx_sel(can_mode_field, mode, can_wk, can_rx);
      spi_active <= (m_sb || m_nm) && !uv;
      spi_limited <= m_fn && !uv;
      watchdog_en <= (m_sb || m_nm || m_sl) && watchdog_mode_field != `WD_OFF;
      watchdog_mode <= watchdog_mode_field;
    end
  end

  // ---------------------------------------------------------------
  // per-channel lin and hv pins
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_lin
      wire here = (i == 0) || (LIN2_PRESENT != 0);
      always @(posedge aclk) begin
        if (!aresetn) begin
          lin_state[2*i+1:2*i] <= `XCVR_OFF;
          lin_rx_out[i] <= 1'b1;
        end else begin
          lin_state[2*i+1:2*i] <= here ? lin_sel(lin_mode_field[2*i+1:2*i], mode) : `XCVR_OFF;
          lin_rx_out[i] <= (here && !uv) ?
            rx_sel(lin_mode_field[2*i+1:2*i], mode, lin_wk[i], lin_rx[i]) : 1'b1;
        end
      end
    end
    for (i = 0; i < HV_PINS; i = i + 1) begin : g_hv
      always @(posedge aclk) begin
        if (!aresetn) begin
          hv_pin_en[i] <= 1'b0;
          hv_pin_ls_en[i] <= 1'b0;
          hv_pin_failsafe[i] <= 1'b0;
        end else if (!HV_PRESENT[i]) begin
          hv_pin_en[i] <= 1'b0;
          hv_pin_ls_en[i] <= 1'b0;
          hv_pin_failsafe[i] <= 1'b0;
        end else begin
          hv_pin_en[i] <= m_cfg && hv_ctrl[2*i];
          hv_pin_ls_en[i] <= m_nm && hv_ctrl[2*i+1];
          hv_pin_failsafe[i] <= m_ov;
        end
      end
    end
  endgenerate
endmodule

// [sim/opmode_chk_sva.sv]
/*
 * checker for the operating-mode block control, watching top-level ports.
 * assumes a single clock aclk and active-low synchronous reset aresetn.
 */
`timescale 1ns/1ps
module opmode_chk #(
  parameter HV_PINS = 8,
  parameter [7:0] HV_PRESENT = 8'hff,
  parameter LIN2_PRESENT = 1
) (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire main_reg_uv,
  input wire main_regulator_en,
  input wire aux_regulator_en,
  input wire [HV_PINS-1:0] hv_pin_en,
  input wire [HV_PINS-1:0] hv_pin_ls_en,
  input wire [HV_PINS-1:0] hv_pin_failsafe,
  input wire buck_boost_en,
  input wire buck_boost_default,
  input wire [2:0] can_state,
  input wire [3:0] lin_state,
  input wire aux_pin_oe,
  input wire aux_pin_open_drain,
  input wire reset_out_low,
  input wire can_rx_out,
  input wire spi_active,
  input wire spi_limited,
  input wire watchdog_en
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence uv_held;
    main_reg_uv [*4];
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  // ----------------------------------------
  // mode decode relations and axi handshakes
  // ----------------------------------------
  AST_RST_MAIN: assert property (!reset_out_low |-> main_regulator_en)
    else $error("reset released with main regulator off");
  AST_SPI_ACT: assert property (spi_active |-> main_regulator_en && !reset_out_low && !spi_limited)
    else $error("serial port active in wrong mode");
  AST_WD_OFF: assert property (watchdog_en |-> !spi_limited)
    else $error("watchdog on in forced normal");
  AST_LS_NORM: assert property (|hv_pin_ls_en |->
      !reset_out_low && !spi_limited && ((hv_pin_ls_en & ~hv_pin_en) == '0))
    else $error("low-side driver outside normal");
  AST_HV_PRESENT: assert property (((hv_pin_en | hv_pin_ls_en) & ~HV_PRESENT[HV_PINS-1:0]) == '0)
    else $error("absent hv pin driven");
  AST_LIN2: assert property (LIN2_PRESENT == 0 |-> lin_state[3:2] == 2'h0)
    else $error("absent lin channel controlled");
  AST_SLEEP_OD: assert property (aux_pin_oe && !main_regulator_en |-> aux_pin_open_drain)
    else $error("aux pin push-pull with main regulator off");
  AST_UV_GATE: assert property (uv_held |-> !spi_active && can_rx_out)
    else $error("pins active during undervoltage");
  AST_CAN_ACT: assert property (can_state == 3'h1 |-> main_regulator_en && !reset_out_low)
    else $error("can active in wrong mode");
  AST_FAILSAFE: assert property (|hv_pin_failsafe |->
      !main_regulator_en && !aux_regulator_en && !buck_boost_en && can_state == 3'h0)
    else $error("fail-safe outside overload");
  AST_BB_DEF: assert property (buck_boost_default |-> buck_boost_en)
    else $error("default voltage with converter off");
  AST_AUX_PIN: assert property (aux_pin_oe |-> !spi_limited)
    else $error("aux pin driven in forced normal");
  AST_RD_ANS: assert property (rd_take |=> s_axi_rvalid)
    else $error("read answer late");
  AST_B_HOLD: assert property (b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
endmodule

// [sim/xcvr_side.sv]
/*
 * far-side model of the bus transceivers: bus receive and wake levels.
 * assumes the bench sets the wanted levels; the model launches them on aclk.
 */
`timescale 1ns/1ps
module xcvr_side (
  input wire aclk,
  input wire [1:0] rx_cmd,
  input wire wake_cmd,
  output logic can_bus_rx = 1'b1,
  output logic [1:0] lin_bus_rx = 2'h3,
  output logic can_wake = 1'b0,
  output logic [1:0] lin_wake = 2'h0
);
  // bus idles recessive high
  always @(posedge aclk) begin
    can_bus_rx <= rx_cmd[0];
    lin_bus_rx <= {2{rx_cmd[1]}};
    can_wake <= wake_cmd;
    lin_wake <= {2{wake_cmd}};
  end
endmodule

// [sim/tb_opmode_ctrl.sv]
/*
 * testbench for the operating-mode block control over axi4-lite.
 * assumes opmode_ctrl, its constants header, the checker and xcvr_side.
 */
`timescale 1ns/1ps
`include "opmode_consts.vh"
module tb_opmode_ctrl;
  localparam HV_PINS = 8;
  localparam [7:0] HV_PRESENT = 8'h3f;
  localparam LIN2_PRESENT = 0;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic main_reg_uv = 1'b0, can_shutdown = 1'b0, wake_cmd = 1'b0;
  logic [1:0] rx_cmd = 2'h3;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp, lin_wake, lin_bus_rx, lin_rx_out;
  wire [31:0] s_axi_rdata;
  wire can_wake, can_bus_rx, main_regulator_en, aux_regulator_en, buck_boost_en;
  wire buck_boost_default, aux_pin_out, aux_pin_oe, aux_pin_open_drain, limp_out, limp_oe;
  wire reset_out_low, can_rx_out, spi_active, spi_limited, watchdog_en;
  wire [HV_PINS-1:0] hv_pin_en, hv_pin_ls_en, hv_pin_failsafe;
  wire [2:0] can_state, watchdog_mode;
  wire [3:0] lin_state;
  int bad_count = 0;
  int n_compared = 0;
  always #25 aclk = ~aclk;
  opmode_ctrl #(.HV_PINS(HV_PINS), .HV_PRESENT(HV_PRESENT), .LIN2_PRESENT(LIN2_PRESENT)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .main_reg_uv, .can_shutdown, .can_wake, .can_bus_rx,
    .lin_wake, .lin_bus_rx, .main_regulator_en, .aux_regulator_en, .hv_pin_en,
    .hv_pin_ls_en, .hv_pin_failsafe, .buck_boost_en, .buck_boost_default, .can_state,
    .lin_state, .aux_pin_out, .aux_pin_oe, .aux_pin_open_drain, .limp_out, .limp_oe,
    .reset_out_low, .can_rx_out, .lin_rx_out, .spi_active, .spi_limited, .watchdog_en,
    .watchdog_mode);
  xcvr_side far_end (.aclk, .rx_cmd, .wake_cmd, .can_bus_rx, .lin_bus_rx, .can_wake,
    .lin_wake);
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // each channel dropped at the edge that takes it; answer taken at its edge
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, `RESP_OKAY});
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk({30'h0, s_axi_rresp}, {30'h0, r});
    if (r == `RESP_OKAY) chk(s_axi_rdata, e);
  endtask
  task automatic settle;
    repeat (5) @(negedge aclk);
  endtask
  task automatic wrap_up;
    if (bad_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // expected {main, aux, bb, rst_low, spi, spi_lim, wd, limp, hv0, ls0, hv7, fs0}
  function automatic logic [11:0] ev(input int m);
    ev = {m != 0 && m != 4 && m != 6, m != 0 && m != 6, m != 0 && m != 6, m == 0 || m >= 4,
      m == 2 || m == 3, m == 1, m >= 2 && m <= 4, m >= 6, m >= 2 && m != 6, m == 3, 1'b0, m == 6};
  endfunction
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk({reset_out_low, main_regulator_en, watchdog_mode}, {1'b1, 1'b0, 3'h2});
    rd(`OFS_MODE, 32'h0, `RESP_OKAY);
    rd(32'h40, 32'h0, `RESP_SLVERR);
    wr(`OFS_REG_CTRL, 32'h5);
    wr(`OFS_HV_CTRL, 32'h8003);
    wr(`OFS_CAN_CTRL, 32'h1);
    wr(`OFS_LIN_CTRL, 32'h5);
    wr(`OFS_FS_CTRL, 32'h2);
    wr(`OFS_WD_CTRL, 32'h2);
    wr(`OFS_STATUS, 32'hffff);
    for (int m = 0; m < 8; m++) begin
      wr(`OFS_MODE, 32'(m));
      settle();
      chk({20'h0, main_regulator_en, aux_regulator_en, buck_boost_en, reset_out_low,
        spi_active, spi_limited, watchdog_en, limp_oe, hv_pin_en[0], hv_pin_ls_en[0],
        hv_pin_en[7], hv_pin_failsafe[0]}, {20'h0, ev(m)});
      if (m == 0 || m == 3 || m == 6)
        chk({25'h0, can_state, lin_state}, m == 3 ? 32'h11 : 32'h0);
      chk({26'h0, buck_boost_default, aux_pin_open_drain, aux_pin_out | aux_pin_oe, limp_out,
        lin_rx_out}, {26'h0, m == 1, m == 4, m >= 2 && m != 6, 1'b0, 2'h3});
      rd(`OFS_MODE, 32'(m), `RESP_OKAY);
    end
    wr(`OFS_MODE, {29'h0, `MODE_STBY});
    wr(`OFS_CAN_CTRL, 32'h3);
    wr(`OFS_FS_CTRL, 32'h4);
    rx_cmd <= 2'h0;
    settle();
    chk({30'h0, limp_oe, can_rx_out}, 32'h2);
    wr(`OFS_MODE, {29'h0, `MODE_SLEEP});
    settle();
    chk({31'h0, can_rx_out}, 32'h1);
    wr(`OFS_MODE, {29'h0, `MODE_RESET});
    rx_cmd <= 2'h3;
    wake_cmd <= 1'b1;
    settle();
    chk({31'h0, can_rx_out}, 32'h0);
    wake_cmd <= 1'b0;
    wr(`OFS_MODE, {29'h0, `MODE_NORM});
    main_reg_uv <= 1'b1;
    can_shutdown <= 1'b1;
    settle();
    chk({27'h0, can_state, spi_active, can_rx_out}, 32'h1);
    wrap_up();
  end
  initial begin
    #400000;
    bad_count++;
    wrap_up();
  end
endmodule
bind opmode_ctrl opmode_chk #(.HV_PINS(HV_PINS), .HV_PRESENT(HV_PRESENT),
  .LIN2_PRESENT(LIN2_PRESENT)) u_chk (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .main_reg_uv,
  .main_regulator_en, .aux_regulator_en, .hv_pin_en, .hv_pin_ls_en, .hv_pin_failsafe,
  .buck_boost_en, .buck_boost_default, .can_state, .lin_state, .aux_pin_oe,
  .aux_pin_open_drain, .reset_out_low, .can_rx_out, .spi_active, .spi_limited,
  .watchdog_en);
